// *** bench/lrc_bus_model.sv ***
// far-side terminal model raising one-cycle events
`timescale 1ns/1ps
module lrc_bus_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [2:0] op,
  input wire logic bcast,
  output lrc_pkg::lrc_evt_t evt,
  output logic monCapture,
  output logic shutdownA,
  output logic shutdownB,
  output logic inhibitFlag
);
  import lrc_pkg::*;
  wire on = !sys_rst;
  // =====================================
  // raw info carries bit 5 inverted, so a passthrough shows
  always_ff @(posedge clock) begin
    evt.resetRt <= on && op == 3'h1;
    evt.msgDone <= on && op[2:1] == 2'h1;
    evt.msgTx <= op[0];
    evt.msgBcast <= bcast;
    evt.msgInfo <= bcast ? 16'ha5c3 : 16'ha5e3;
    monCapture <= on && op == 3'h4;
    shutdownA <= on && op == 3'h5;
    shutdownB <= on && op == 3'h6;
    inhibitFlag <= on && op == 3'h7;
  end
endmodule

// *** bench/lrc_compat_checker.sv ***
// assertions on the legacy compat block ports
`timescale 1ns/1ps
module lrc_compat_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire lrc_pkg::lrc_apb_req_t apbReq,
  input wire lrc_pkg::lrc_evt_t evt,
  input wire logic monCapture,
  input wire logic legInitReq,
  input wire logic shutdownA,
  input wire logic inhibitFlag,
  input wire logic legInitStart,
  input wire logic decoderReset,
  input wire logic chanAEnable,
  input wire logic chanBEnable,
  input wire logic termFlagEnable,
  input wire logic [15:0] monPtr,
  input wire logic irq
);
  import lrc_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
  wire irqCause = monCapture || evt.resetRt || apbWr;
  // =====================================
  // named steps
  sequence rstRt_s;
    evt.resetRt;
  endsequence
  dec_pulse_a: assert property (
    decoderReset == $past(evt.resetRt)) else $error("decoder pulse");
  chan_on_a: assert property (
    rstRt_s |=> chanAEnable && chanBEnable) else $error("chan enable");
  flag_on_a: assert property (
    rstRt_s |=> termFlagEnable) else $error("flag enable");
  chan_shut_a: assert property (
    shutdownA && !evt.resetRt |=> !chanAEnable) else $error("chan shut");
  flag_inhibit_a: assert property (
    inhibitFlag && !evt.resetRt |=> !termFlagEnable) else $error("inhibit");
  leg_start_a: assert property (
    legInitStart |-> $past(legInitReq)) else $error("leg start");
  // reload shows as a step backwards
  ptr_step_a: assert property (
    monCapture |=> monPtr == $past(monPtr) + 16'h0008 ||
    monPtr < $past(monPtr)) else $error("ptr step");
  ptr_hold_a: assert property (
    !monCapture && !apbWr |=> $stable(monPtr)) else $error("ptr moved");
  irq_rise_a: assert property (
    $rose(irq) |-> $past(irqCause)) else $error("irq cause");
endmodule
bind lrc_legacy_compat lrc_compat_checker u_chk (
  .clock, .sys_rst, .apbReq, .evt, .monCapture, .legInitReq, .shutdownA,
  .inhibitFlag, .legInitStart, .decoderReset, .chanAEnable, .chanBEnable,
  .termFlagEnable, .monPtr, .irq);

// *** bench/lrc_legacy_compat_tb.sv ***
// self-checking testbench for the legacy compat block
`timescale 1ns/1ps
`include "lrc_defines.svh"
module lrc_legacy_compat_tb;
  import lrc_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  lrc_apb_req_t apbReq = '0;
  lrc_apb_rsp_t apbRsp;
  lrc_evt_t evt;
  logic monCapture, shutdownA, shutdownB, inhibitFlag, legInitStart;
  logic decoderReset, chanAEnable, chanBEnable, termFlagEnable, irq;
  logic legInitReq = 1'b0;
  logic bcast = 1'b0;
  logic [2:0] op = 3'h0;
  logic [15:0] monPtr;
  logic [31:0] rd;
  logic err;
  logic [15:0] ptrs [7] = '{16'h2000, 16'h2008, 16'h2010, 16'h2018,
    16'h2020, 16'h2000, 16'h2008};
  int fails = 0;
  int n_tests = 0;
  always #25 clock = ~clock;
  lrc_legacy_compat u_dut (.clock, .sys_rst, .apbReq, .apbRsp, .evt,
    .monCapture, .legInitReq, .shutdownA, .shutdownB, .inhibitFlag,
    .legInitStart, .decoderReset, .chanAEnable, .chanBEnable,
    .termFlagEnable, .monPtr, .irq);
  lrc_bus_model u_bus (.clock, .sys_rst, .op, .bcast, .evt, .monCapture,
    .shutdownA, .shutdownB, .inhibitFlag);
  // =====================================
  // checks and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // idle edge after release keeps psel from two writes in one step
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    i = 0;
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
      i++;
    end while (apbRsp.pready !== 1'b1 && i < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (i >= 20) begin
      fails++;
      wrap_up();
    end
    @(posedge clock);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
    input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic ev(input logic [2:0] o, input logic b);
    op <= o;
    bcast <= b;
    @(posedge clock);
    op <= 3'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic leg(input logic e);
    legInitReq <= 1'b1;
    @(posedge clock);
    legInitReq <= 1'b0;
    @(negedge clock);
    chk(32'(legInitStart), 32'(e), "leg start");
    @(posedge clock);
  endtask
  // =====================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rdc(`LRC_OFF_STATUS, 32'h7, "status");
    leg(1'b1);
    xfer(1'b1, `LRC_OFF_CTRL, 32'h3);
    leg(1'b0);
    xfer(1'b1, `LRC_OFF_CTRL, 32'h1);
    ev(3'h2, 1'b1);
    rdc(`LRC_OFF_INFORX, 32'ha5e3, "rx info");
    ev(3'h3, 1'b0);
    rdc(`LRC_OFF_INFOTX, 32'ha5c3, "tx info");
    $display("test legal info done");
    ev(3'h5, 1'b0);
    ev(3'h6, 1'b0);
    ev(3'h7, 1'b0);
    rdc(`LRC_OFF_STATUS, 32'h0, "shut");
    op <= 3'h1;
    @(posedge clock);
    op <= 3'h0;
    @(posedge clock);
    @(negedge clock);
    chk(32'(decoderReset), 32'h1, "decoder");
    @(posedge clock);
    xfer(1'b0, `LRC_OFF_TIMETAG, 32'h0);
    chk(32'(rd < 32'h8), 32'h1, "tag clear");
    rdc(`LRC_OFF_STATUS, 32'h7, "reenable");
    rdc(`LRC_OFF_CTRL, 32'h1, "exec");
    rdc(`LRC_OFF_IRQSTAT, 32'h2, "rt stat");
    xfer(1'b1, `LRC_OFF_IRQCLR, 32'h3);
    $display("test reset rt done");
    xfer(1'b1, `LRC_OFF_MONINIT, 32'h2000);
    xfer(1'b1, `LRC_OFF_MONCOUNT, 32'h4);
    xfer(1'b1, `LRC_OFF_IRQEN, 32'h1);
    for (int i = 0; i < 6; i++) begin
      rdc(`LRC_OFF_MONPTR, ptrs[i], "ptr");
      ev(3'h4, 1'b0);
      chk(32'(irq), 32'(i > 2), "block irq");
    end
    rdc(`LRC_OFF_MONPTR, ptrs[6], "ptr");
    rdc(`LRC_OFF_IRQSTAT, 32'h1, "block stat");
    rdc(`LRC_OFF_INTADDR, 32'h2018, "int addr");
    xfer(1'b1, `LRC_OFF_MONPTR, 32'h0);
    chk(32'(err), 32'h1, "ro write");
    rdc(`LRC_OFF_MONPTR, 32'h2008, "ptr kept");
    xfer(1'b0, 12'h0f0, 32'h0);
    chk(32'(err), 32'h1, "unmapped");
    xfer(1'b1, `LRC_OFF_IRQEN, 32'h0);
    chk(32'(irq), 32'h0, "masked");
    xfer(1'b1, `LRC_OFF_IRQEN, 32'h1);
    chk(32'(irq), 32'h1, "unmasked");
    xfer(1'b1, `LRC_OFF_IRQCLR, 32'h1);
    chk(32'(irq), 32'h0, "cleared");
    $display("test monitor done");
    wrap_up();
  end
endmodule

// *** rtl/lrc_defines.svh ***
// constants for the legacy rt/monitor compatibility block
`ifndef LRC_DEFINES_SVH
`define LRC_DEFINES_SVH
// =====================================================
// register byte offsets
`define LRC_OFF_CTRL 12'h000
`define LRC_OFF_STATUS 12'h004
`define LRC_OFF_TIMETAG 12'h01c
`define LRC_OFF_MONINIT 12'h020
`define LRC_OFF_MONCOUNT 12'h024
`define LRC_OFF_MONPTR 12'h028
`define LRC_OFF_INTADDR 12'h02c
`define LRC_OFF_INFOTX 12'h030
`define LRC_OFF_INFORX 12'h034
`define LRC_OFF_IRQSTAT 12'h038
`define LRC_OFF_IRQEN 12'h03c
`define LRC_OFF_IRQCLR 12'h040
// =====================================================
// fields and values
`define LRC_CTRL_EXEC 0
`define LRC_CTRL_LEGSEL 1
`define LRC_CTRL_RST 1'h1
`define LRC_NUM_CHAN 2
`define LRC_INFO_BCAST 5
`define LRC_DESC_STEP 16'h0008
`define LRC_MONINIT_RST 16'h2000
`define LRC_IRQ_BLOCK 0
`define LRC_IRQ_RESETRT 1
`define LRC_IRQ_W 2
`define LRC_LEG_ZERO 1'h0
`endif

// *** rtl/lrc_legacy_compat.sv ***
// legacy rt and monitor compatibility logic with apb registers
//
// Operation
// (R1) init legalization only when select is zero
// (R2) broadcast sets bit 5 of info words
// (R3) reset rt mode code resets decoder
// (R4) reset rt clears time tag register
// (R5) reset rt re-enables both bus channels
// (R6) reset rt re-enables terminal flag bit
// (R7) execution enable stays set after reset rt
// (R8) block count interrupt after nth capture
// (R9) pointer not rewound at block interrupt
// (R10) reload pointer after one extra capture
// (R11) pointer advances eight words per message
// (R12) interrupt address word holds last descriptor
`timescale 1ns/1ps
`include "lrc_defines.svh"
module lrc_legacy_compat (
  input wire logic clock,
  input wire logic sys_rst,
  input wire lrc_pkg::lrc_apb_req_t apbReq,
  output lrc_pkg::lrc_apb_rsp_t apbRsp,
  input wire lrc_pkg::lrc_evt_t evt,
  input wire logic monCapture,
  input wire logic legInitReq,
  input wire logic shutdownA,
  input wire logic shutdownB,
  input wire logic inhibitFlag,
  output logic legInitStart,
  output logic decoderReset,
  output logic chanAEnable,
  output logic chanBEnable,
  output logic termFlagEnable,
  output logic [15:0] monPtr,
  output logic irq
);
  import lrc_pkg::*;

  // =====================================================
  // state
  logic execEn_reg;
  logic legSel_reg;
  logic [31:0] timeTag_reg;
  logic [15:0] monInit_reg;
  logic [15:0] monCount_reg;
  logic [15:0] monPtr_reg;
  logic [15:0] monNum_reg;
  logic [15:0] intAddrWord_reg;
  logic [15:0] infoTx_reg;
  logic [15:0] infoRx_reg;
  logic [`LRC_IRQ_W-1:0] irqStat_reg;
  logic [`LRC_IRQ_W-1:0] irqEn_reg;
  wire [`LRC_NUM_CHAN-1:0] chanOn;
  logic termFlag_reg;
  logic legStart_reg;
  logic decRst_reg;
  logic [31:0] rdata_reg;
  lrc_mon_t monState_reg;
  lrc_mon_t monState_next;
  logic [15:0] monPtr_next;
  logic [15:0] monNum_next;
  logic [15:0] intAddrWord_next;

  // =====================================================
  // apb decode
  wire apbSetup = apbReq.psel & ~apbReq.penable;
  wire wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
  wire [11:0] addr = apbReq.paddr;
  wire selCtrl = addr == `LRC_OFF_CTRL;
  wire selStatus = addr == `LRC_OFF_STATUS;
  wire selTime = addr == `LRC_OFF_TIMETAG;
  wire selInit = addr == `LRC_OFF_MONINIT;
  wire selCount = addr == `LRC_OFF_MONCOUNT;
  wire selPtr = addr == `LRC_OFF_MONPTR;
  wire selIntAddr = addr == `LRC_OFF_INTADDR;
  wire selTx = addr == `LRC_OFF_INFOTX;
  wire selRx = addr == `LRC_OFF_INFORX;
  wire selIst = addr == `LRC_OFF_IRQSTAT;
  wire selIen = addr == `LRC_OFF_IRQEN;
  wire selIclr = addr == `LRC_OFF_IRQCLR;
  wire mapped = selCtrl | selStatus | selTime | selInit | selCount |
    selPtr | selIntAddr | selTx | selRx | selIst | selIen | selIclr;
  // read-only and write-only registers refuse the wrong direction
  wire badWr = selStatus | selPtr | selIntAddr | selTx | selRx | selIst;
  wire badRd = selIclr;
  wire accErr = ~mapped | (apbReq.pwrite ? badWr : badRd);

  wire [31:0] rdMux =
    selCtrl ? {30'h0, legSel_reg, execEn_reg} :
    selStatus ? {29'h0, termFlag_reg, chanOn} :
    selTime ? timeTag_reg :
    selInit ? {16'h0, monInit_reg} :
    selCount ? {16'h0, monCount_reg} :
    selPtr ? {16'h0, monPtr_reg} :
    selIntAddr ? {16'h0, intAddrWord_reg} :
    selTx ? {16'h0, infoTx_reg} :
    selRx ? {16'h0, infoRx_reg} :
    selIst ? {30'h0, irqStat_reg} :
    selIen ? {30'h0, irqEn_reg} : 32'h0;

  wire slvErr = apbReq.psel & apbReq.penable & accErr;
  // zero wait states: pready never drops
  assign apbRsp = '{pready: 1'b1, pslverr: slvErr, prdata: rdata_reg};

  // =====================================================
  // message events
  wire resetRt = evt.resetRt;
  wire msgDone = evt.msgDone;
  // (R2) broadcast flag in info
  wire [15:0] infoWord = {evt.msgInfo[15:`LRC_INFO_BCAST+1], evt.msgBcast,
    evt.msgInfo[`LRC_INFO_BCAST-1:0]};

  wire ctrlWr = wrEn & selCtrl;
  wire initWr = wrEn & selInit;
  // a capture meeting a base write is dropped, the base wins
  wire capEvt = monCapture & ~initWr;
  // (R11) eight word step
  wire [15:0] ptrStep = monPtr_reg + `LRC_DESC_STEP;
  // zero count only hits after the 16-bit count wraps
  wire lastOfBlock = (monNum_reg + 16'h0001) == monCount_reg;
  // (R8) nth capture of the block
  wire blockHit = capEvt & (monState_reg == LRC_MON_RUN) & lastOfBlock;
  wire [`LRC_IRQ_W-1:0] irqSet = {resetRt, blockHit};
  wire [`LRC_IRQ_W-1:0] irqClr = (wrEn & selIclr) ?
    apbReq.pwdata[`LRC_IRQ_W-1:0] : {`LRC_IRQ_W{1'b0}};

  // =====================================================
  // control and time tag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      execEn_reg <= `LRC_CTRL_RST;
      legSel_reg <= `LRC_LEG_ZERO;
    end else if (ctrlWr) begin
      // (R7) reset rt never clears exec
      execEn_reg <= apbReq.pwdata[`LRC_CTRL_EXEC];
      legSel_reg <= apbReq.pwdata[`LRC_CTRL_LEGSEL];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      timeTag_reg <= 32'h0;
    end else if (resetRt) begin
      // (R4) clear time tag
      timeTag_reg <= 32'h0;
    end else if (wrEn & selTime) begin
      timeTag_reg <= apbReq.pwdata;
    end else begin
      timeTag_reg <= timeTag_reg + 32'h1;
    end
  end

  // =====================================================
  // rt side effects
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      decRst_reg <= 1'b0;
      legStart_reg <= 1'b0;
    end else begin
      // (R3) one pulse resets decoder
      decRst_reg <= resetRt;
      // (R1) only select zero starts init
      legStart_reg <= legInitReq & (legSel_reg == `LRC_LEG_ZERO);
    end
  end

  // one enable per bus channel, index 0 is channel a
  wire [`LRC_NUM_CHAN-1:0] shutdown = {shutdownB, shutdownA};
  for (genvar ch = 0; ch < `LRC_NUM_CHAN; ch++) begin : g_chan
    logic chanOn_reg;
    // (R5) reset rt wins over shutdown
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        chanOn_reg <= 1'b1;
      end else if (resetRt) begin
        chanOn_reg <= 1'b1;
      end else if (shutdown[ch]) begin
        chanOn_reg <= 1'b0;
      end
    end
    assign chanOn[ch] = chanOn_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      termFlag_reg <= 1'b1;
    end else if (resetRt) begin
      // (R6) reset rt wins over inhibit
      termFlag_reg <= 1'b1;
    end else if (inhibitFlag) begin
      termFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      infoTx_reg <= 16'h0;
      infoRx_reg <= 16'h0;
    end else if (msgDone & evt.msgTx) begin
      infoTx_reg <= infoWord;
    end else if (msgDone) begin
      infoRx_reg <= infoWord;
    end
  end

  // =====================================================
  // monitor descriptor pointer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      monInit_reg <= `LRC_MONINIT_RST;
      monCount_reg <= 16'h0;
    end else begin
      if (initWr) begin
        monInit_reg <= apbReq.pwdata[15:0];
      end
      if (wrEn & selCount) begin
        monCount_reg <= apbReq.pwdata[15:0];
      end
    end
  end

  // =====================================================
  // monitor next state
  always_comb begin
    monState_next = monState_reg;
    monPtr_next = monPtr_reg;
    monNum_next = monNum_reg;
    intAddrWord_next = intAddrWord_reg;
    if (initWr) begin
      // a new base restarts the block at once
      monPtr_next = apbReq.pwdata[15:0];
      monNum_next = 16'h0;
      monState_next = LRC_MON_RUN;
    end else if (capEvt) begin
      unique case (monState_reg)
        LRC_MON_RUN: begin
          // (R11) next descriptor
          monPtr_next = ptrStep;
          if (lastOfBlock) begin
            // (R9) keep advancing, no rewind
            monState_next = LRC_MON_EXTRA;
            // (R12) last descriptor into interrupt address word
            intAddrWord_next = monPtr_reg;
          end else begin
            monNum_next = monNum_reg + 16'h0001;
          end
        end
        LRC_MON_EXTRA: begin
          // (R10) reload after the extra one
          monPtr_next = monInit_reg;
          monNum_next = 16'h0;
          monState_next = LRC_MON_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      monPtr_reg <= `LRC_MONINIT_RST;
      monNum_reg <= 16'h0;
      monState_reg <= LRC_MON_RUN;
      intAddrWord_reg <= 16'h0;
    end else begin
      monPtr_reg <= monPtr_next;
      monNum_reg <= monNum_next;
      monState_reg <= monState_next;
      intAddrWord_reg <= intAddrWord_next;
    end
  end

  // =====================================================
  // interrupts, set wins over clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStat_reg <= {`LRC_IRQ_W{1'b0}};
      irqEn_reg <= {`LRC_IRQ_W{1'b0}};
    end else begin
      // (R8) block count event sticky
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
      if (wrEn & selIen) begin
        irqEn_reg <= apbReq.pwdata[`LRC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0;
    end else if (apbSetup & ~apbReq.pwrite) begin
      rdata_reg <= rdMux;
    end
  end

  assign irq = |(irqStat_reg & irqEn_reg);
  assign legInitStart = legStart_reg;
  assign decoderReset = decRst_reg;
  assign chanAEnable = chanOn[0];
  assign chanBEnable = chanOn[1];
  assign termFlagEnable = termFlag_reg;
  assign monPtr = monPtr_reg;
endmodule

// *** rtl/lrc_pkg.sv ***
// types for the legacy rt/monitor compatibility block
package lrc_pkg;
  // =====================================================
  // apb request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lrc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lrc_apb_rsp_t;
  // =====================================================
  // events from the protocol engine
  typedef struct packed {
    logic resetRt;
    logic msgDone;
    logic msgBcast;
    logic msgTx;
    logic [15:0] msgInfo;
  } lrc_evt_t;
  typedef enum logic [0:0] {LRC_MON_RUN, LRC_MON_EXTRA} lrc_mon_t;
endpackage
